// ==== bench/adc_ctrl_monitor.sv ====
`timescale 1ns/10ps
module adc_ctrl_monitor #(
  parameter int CONV_CLOCKS = 24,
  parameter int PWRUP_CYC   = 4
) (
  input wire logic                        mclk,
  input wire logic                        rst,
  input wire logic                        ce,
  input wire adc_ctrl_pkg::sfr_req_t      sfr_req,
  input wire logic                        conv_irq_enable,
  input wire adc_ctrl_pkg::timer_events_t tev,
  input wire logic [11:0]                 ana_result,
  input wire logic [7:0]                  p1_pin_in,
  input wire logic [7:0]                  sfr_rdata,
  input wire logic                        conv_irq,
  input wire adc_ctrl_pkg::analog_ctrl_t  analog_ctrl,
  input wire logic                        sar_sample,
  input wire logic                        sar_step,
  input wire logic [7:0]                  p1_digital_in,
  input wire logic [7:0]                  p1_in_buf_off
);
  int steps;

  // Counts conversion clocks since the last sample pulse
  always_ff @(posedge mclk) begin
    if (rst || sar_sample) begin
      steps <= 0;
    end else if (sar_step) begin
      steps <= steps + 1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst || !ce);

  sequence ctl_wr;
    sfr_req.wr && sfr_req.addr == 8'hc4;
  endsequence

  a_ctrl_mirror: assert property (ctl_wr |-> ##2 {analog_ctrl.conv_power_on,
    analog_ctrl.diff_mode_sel, analog_ctrl.auto_zero_on} == $past(sfr_req.wdata[7:5], 2))
    else $error("control bits not copied to converter");
  a_single_chan: assert property ((ctl_wr and !sfr_req.wdata[6]) |-> ##2
    analog_ctrl.neg_is_ground && analog_ctrl.pos_input == $past(sfr_req.wdata[2:0], 2))
    else $error("single-ended channel wrong");
  a_diff_pair: assert property ((ctl_wr and sfr_req.wdata[6]) |-> ##2
    !analog_ctrl.neg_is_ground &&
    analog_ctrl.pos_input == {$past(sfr_req.wdata[2:1], 2), 1'b0} &&
    analog_ctrl.neg_input == {$past(sfr_req.wdata[2:1], 2), 1'b1})
    else $error("differential pair wrong");
  // Register loads on the write edge, the output one edge later
  a_buf_mirror: assert property (sfr_req.wr && sfr_req.addr == 8'h92 |-> ##2
    p1_in_buf_off == $past(sfr_req.wdata, 2)) else $error("buffer disable not updated");
  a_gate_digital: assert property ((p1_digital_in & p1_in_buf_off & $past(p1_in_buf_off))
    == 8'h00) else $error("analog-only pin reads one");
  a_irq_cause: assert property (conv_irq |-> $past(conv_irq_enable))
    else $error("interrupt without enable");
  a_no_restart: assert property (conv_irq |-> !sar_sample)
    else $error("conversion started with done flag set");
  // The last step pulse is still uncounted when the interrupt rises
  a_conv_length: assert property ($rose(conv_irq) |-> steps + int'(sar_step) == CONV_CLOCKS)
    else $error("conversion clock count wrong");
  a_sample_pulse: assert property (sar_sample |=> !sar_sample [*8])
    else $error("sample pulse too long or too soon");
  a_cfg_reserved: assert property (sfr_req.addr == 8'hc3 |=> sfr_rdata[3:2] == 2'b00)
    else $error("reserved config bits read nonzero");
  a_unmapped_zero: assert property (!(sfr_req.addr inside {8'h92, 8'hc3, 8'hc4, 8'hc5,
    8'hc6}) |=> sfr_rdata == 8'h00) else $error("unmapped read nonzero");
endmodule

bind adc_ctrl adc_ctrl_monitor #(.CONV_CLOCKS(CONV_CLOCKS), .PWRUP_CYC(PWRUP_CYC)) u_mon (
  .mclk(mclk), .rst(rst), .ce(ce), .sfr_req(sfr_req), .conv_irq_enable(conv_irq_enable),
  .tev(tev), .ana_result(ana_result), .p1_pin_in(p1_pin_in), .sfr_rdata(sfr_rdata),
  .conv_irq(conv_irq), .analog_ctrl(analog_ctrl), .sar_sample(sar_sample),
  .sar_step(sar_step), .p1_digital_in(p1_digital_in), .p1_in_buf_off(p1_in_buf_off));

// ==== bench/sar_core_model.sv ====
`timescale 1ns/10ps
module sar_core_model (
  input  wire logic                       mclk,
  input  wire adc_ctrl_pkg::analog_ctrl_t analog_ctrl,
  input  wire logic [11:0]                level,
  output logic [11:0]                     ana_result
);
  // Powered down the core holds no valid code; the inverse keeps stale data from matching
  always_ff @(posedge mclk) begin
    ana_result <= analog_ctrl.conv_power_on ? level : ~level;
  end
endmodule

// ==== bench/tb_adc_ctrl.sv ====
`timescale 1ns/10ps
module tb_adc_ctrl;
  logic                        mclk = 1'b0;
  logic                        rst = 1'b1;
  adc_ctrl_pkg::sfr_req_t      sfr_req = '0;
  logic                        irq_en = 1'b1;
  adc_ctrl_pkg::timer_events_t tev = '0;
  logic [4:0]                  ev_mask = 5'h00;
  logic [11:0]                 level = 12'h000;
  logic [11:0]                 ana_result;
  logic [7:0]                  pins = 8'hff;
  logic [7:0]                  sfr_rdata;
  logic [7:0]                  p1_digital_in;
  logic [7:0]                  p1_in_buf_off;
  logic                        conv_irq;
  adc_ctrl_pkg::analog_ctrl_t  analog_ctrl;
  logic [7:0]                  rd_val;
  logic [15:0]                 res;
  int                          num_errors = 0;
  int                          comparisons = 0;
  int                          cycles = 0;
  int                          ev_cnt = 0;

  always #2 mclk = ~mclk;

  // Overflow pulses every fourth cycle; the split flag is a level
  always @(posedge mclk) begin
    ev_cnt <= ev_cnt + 1;
    tev <= (ev_cnt % 4 == 0) ? ev_mask : (ev_mask & 5'h02);
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      wrap_up();
    end
  end

  adc_ctrl #(.PWRUP_CYC(4)) dut (
    .mclk(mclk), .rst(rst), .ce(1'b1), .sfr_req(sfr_req), .conv_irq_enable(irq_en),
    .tev(tev), .ana_result(ana_result), .p1_pin_in(pins), .sfr_rdata(sfr_rdata),
    .conv_irq(conv_irq), .analog_ctrl(analog_ctrl), .sar_sample(), .sar_step(),
    .p1_digital_in(p1_digital_in), .p1_in_buf_off(p1_in_buf_off));
  sar_core_model core (.mclk(mclk), .analog_ctrl(analog_ctrl), .level(level),
    .ana_result(ana_result));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) sfr_req <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge mclk) sfr_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk) sfr_req <= '{addr: a, wr: 1'b0, wdata: 8'h00};
    @(posedge mclk) #1 rd_val = sfr_rdata;
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    while (conv_irq !== 1'b1 && n < 4000) begin
      @(posedge mclk) #1 n++;
    end
  endtask

  // Power cycle, configure, start; result lands in res
  task automatic run(input logic [7:0] cfg, input logic [7:0] ctl, input logic [11:0] lv,
                     output int n);
    wr(8'hc4, 8'h00);
    level <= lv;
    wr(8'hc3, cfg);
    wr(8'hc4, ctl);
    wr(8'hc4, ctl | 8'h08);
    wait_irq(n);
    rd(8'hc6);
    res[15:8] = rd_val;
    rd(8'hc5);
    res[7:0] = rd_val;
  endtask

  task automatic t_regs();
    logic [7:0] addrs [6] = '{8'h92, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'h90};
    foreach (addrs[i]) begin
      rd(addrs[i]);
      chk(rd_val, 16'h0000);
    end
    wr(8'hc4, 8'h98);
    rd(8'hc4);
    chk(rd_val, 16'h0080);
    wr(8'hc3, 8'hf3);
    rd(8'hc3);
    chk(rd_val, 16'h00f3);
  endtask

  task automatic t_aio();
    wr(8'h92, 8'ha5);
    repeat (4) @(posedge mclk);
    #1 chk(p1_digital_in, 16'h005a);
    chk(p1_in_buf_off, 16'h00a5);
    rd(8'h92);
    chk(rd_val, 16'h00a5);
    wr(8'h92, 8'h00);
    repeat (4) @(posedge mclk);
    #1 chk(p1_digital_in, 16'h00ff);
  endtask

  task automatic t_format();
    logic [43:0] fmt [8] = '{{8'h00, 8'h80, 12'hfff, 16'hfff0}, {8'h10, 8'h80, 12'hfff, 16'h0fff},
      {8'h10, 8'h85, 12'h800, 16'h0800}, {8'h00, 8'hc0, 12'hfff, 16'h7ff0},
      {8'h10, 8'he2, 12'hfff, 16'h07ff}, {8'h00, 8'hc4, 12'h000, 16'h8000},
      {8'h10, 8'hc6, 12'h000, 16'h0800}, {8'h10, 8'hc0, 12'h400, 16'h0c00}};
    int n;
    foreach (fmt[i]) begin
      run(fmt[i][43:36], fmt[i][35:28], fmt[i][27:16], n);
      chk(res, fmt[i][15:0]);
      rd(8'hc4);
      chk(rd_val, {8'h00, fmt[i][35:28] | 8'h10});
    end
  endtask

  task automatic t_clocks();
    int n;
    int d;
    for (int k = 0; k < 8; k++) begin
      d = (k < 6) ? (2 << k) : 8;
      @(posedge mclk) ev_mask <= (k == 6) ? 5'h01 : ((k == 7) ? 5'h06 : 5'h00);
      run({k[2:0], 5'h10}, 8'h80, 12'h123, n);
      chk(res, 16'h0123);
      chk(16'(n >= 23 * d && n <= 25 * d + 8), 16'h0001);
    end
  endtask

  task automatic t_trig();
    int n;
    @(posedge mclk) ev_mask <= 5'h00;
    wr(8'hc4, 8'h00);
    wr(8'hc3, 8'h11);
    wr(8'hc4, 8'h80);
    wr(8'hc4, 8'h88);
    repeat (300) @(posedge mclk);
    #1 chk(conv_irq, 16'h0000);
    @(posedge mclk) ev_mask <= 5'h10;
    wait_irq(n);
    chk(16'(n > 40 && n < 100), 16'h0001);
    @(posedge mclk) ev_mask <= 5'h08;
    run(8'h13, 8'h80, 12'h000, n);
    chk(16'(n < 400), 16'h0001);
    @(posedge mclk) ev_mask <= 5'h00;
    run(8'h12, 8'h80, 12'h000, n);
    chk(16'(n < 400), 16'h0001);
    @(posedge mclk) irq_en <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(conv_irq, 16'h0000);
    @(posedge mclk) irq_en <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(conv_irq, 16'h0001);
    wr(8'hc4, 8'h80);
    @(posedge mclk) #1 chk(conv_irq, 16'h0000);
    wait_irq(n);
    chk(16'(n < 100), 16'h0001);
    wr(8'hc4, 8'h00);
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_aio();
    t_format();
    t_clocks();
    t_trig();
    wrap_up();
  end
endmodule

// ==== rtl/adc_ctrl.sv ====
`timescale 1ns/10ps
`include "adc_ctrl_regs.svh"

module adc_ctrl #(
  parameter int CONV_CLOCKS = `CONV_CLOCKS,
  parameter int PWRUP_CYC   = `PWRUP_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire adc_ctrl_pkg::sfr_req_t      sfr_req,
  input  wire logic                        conv_irq_enable,
  input  wire adc_ctrl_pkg::timer_events_t tev,
  input  wire logic [11:0]                 ana_result,
  input  wire logic [7:0]                  p1_pin_in,
  output logic [7:0]                       sfr_rdata,
  output logic                             conv_irq,
  output adc_ctrl_pkg::analog_ctrl_t       analog_ctrl,
  output logic                             sar_sample,
  output logic                             sar_step,
  output logic [7:0]                       p1_digital_in,
  output logic [7:0]                       p1_in_buf_off
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (CONV_CLOCKS < 2 || CONV_CLOCKS > 31) begin : g_bad_conv
      $error("CONV_CLOCKS must lie in 2..31");
    end
    if (PWRUP_CYC < 1 || PWRUP_CYC > 4095) begin : g_bad_pwrup
      $error("PWRUP_CYC must lie in 1..4095");
    end
  endgenerate

  localparam logic [4:0]  LAST_STEP  = 5'(CONV_CLOCKS - 1);
  localparam logic [11:0] SETTLE_CYC = 12'(PWRUP_CYC);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                      power_reg;
  logic                      diff_reg;
  logic                      az_reg;
  logic                      done_reg;
  logic                      done_next;
  logic                      go_reg;
  logic                      go_next;
  logic [2:0]                chs_reg;
  logic [2:0]                cks_reg;
  logic                      rj_reg;
  adc_ctrl_pkg::trig_t       trig_reg;
  logic [7:0]                aio_reg;
  logic [7:0]                res_hi_reg;
  logic [7:0]                res_lo_reg;
  adc_ctrl_pkg::conv_state_t state_reg;
  logic [4:0]                step_reg;
  logic [11:0]               settle_reg;
  logic [7:0]                p1_meta_reg;
  logic [7:0]                p1_sync_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       ctl_write;
  logic       cfg_write;
  logic       aio_write;
  logic       busy;
  logic       settled;
  logic       tick;
  logic       trigger_hit;
  logic       start;
  logic       conv_done;
  logic       manual;
  logic       go_accept;
  logic [7:0] fmt_hi;
  logic [7:0] fmt_lo;
  logic [7:0] ctl_view;
  logic [7:0] cfg_view;
  logic [7:0] rd_mux;

  assign ctl_write = sfr_req.wr && (sfr_req.addr == `CTL_ADDR);
  assign cfg_write = sfr_req.wr && (sfr_req.addr == `CFG_ADDR);
  assign aio_write = sfr_req.wr && (sfr_req.addr == `AIO_ADDR);
  assign busy      = (state_reg == adc_ctrl_pkg::ST_CONV);
  assign settled   = (settle_reg == SETTLE_CYC);
  assign manual    = (trig_reg == adc_ctrl_pkg::TRIG_SOFT);

  // Start source per trigger mode
  assign trigger_hit = (trig_reg == adc_ctrl_pkg::TRIG_TIMER0) ? tev.timer0_overflow :
                       (trig_reg == adc_ctrl_pkg::TRIG_TIMER3) ? tev.timer3_overflow :
                       1'b1;

  // A set request is refused while a conversion or its flag is pending
  assign go_accept = ctl_write && sfr_req.wdata[`CTL_GO_BIT] && power_reg &&
                     !go_reg && !done_reg;
  // Start waits out the settle time even if software arms early
  assign start     = go_reg && !busy && !done_reg && settled && power_reg &&
                     trigger_hit;
  assign conv_done = busy && tick && (step_reg == LAST_STEP);

  // Hardware set wins over a software clear in the same cycle
  assign done_next = conv_done ||
                     (done_reg && !(ctl_write && !sfr_req.wdata[`CTL_DONE_BIT]));
  // In manual mode completion clears the start bit; the other modes
  // keep it armed so conversions repeat until disabled or manual
  assign go_next   = power_reg &&
                     ((go_reg && !(conv_done && manual)) || go_accept);

  assign ctl_view = {power_reg, diff_reg, az_reg, done_reg, go_reg, chs_reg};
  assign cfg_view = {cks_reg, rj_reg, 2'b00, trig_reg};
  assign rd_mux   = (sfr_req.addr == `CTL_ADDR)    ? ctl_view   :
                    (sfr_req.addr == `CFG_ADDR)    ? cfg_view   :
                    (sfr_req.addr == `AIO_ADDR)    ? aio_reg    :
                    (sfr_req.addr == `RES_LO_ADDR) ? res_lo_reg :
                    (sfr_req.addr == `RES_HI_ADDR) ? res_hi_reg :
                    8'h00;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  conv_clock_gen u_clk (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .clock_sel (cks_reg),
    .tev       (tev),
    .tick      (tick)
  );

  result_format u_fmt (
    .code          (ana_result),
    .diff_mode_sel (diff_reg),
    .right_justify (rj_reg),
    .high_byte     (fmt_hi),
    .low_byte      (fmt_lo)
  );

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      power_reg <= 1'(`CTL_RESET >> `CTL_POWER_BIT);
      diff_reg  <= 1'b0;
      az_reg    <= 1'b0;
      chs_reg   <= 3'h0;
      done_reg  <= 1'b0;
      go_reg    <= 1'b0;
    end else if (ce) begin
      done_reg <= done_next;
      go_reg   <= go_next;
      if (ctl_write) begin
        power_reg <= sfr_req.wdata[`CTL_POWER_BIT];
        diff_reg  <= sfr_req.wdata[`CTL_DIFF_BIT];
        az_reg    <= sfr_req.wdata[`CTL_AZ_BIT];
        chs_reg   <= sfr_req.wdata[`CTL_CHS_MSB:`CTL_CHS_LSB];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cks_reg  <= 3'h0;
      rj_reg   <= 1'b0;
      trig_reg <= adc_ctrl_pkg::TRIG_SOFT;
      aio_reg  <= `AIO_RESET;
    end else if (ce) begin
      // Reserved configuration bits are not stored and read as zero
      if (cfg_write) begin
        cks_reg  <= sfr_req.wdata[`CFG_CKS_MSB:`CFG_CKS_LSB];
        rj_reg   <= sfr_req.wdata[`CFG_RJ_BIT];
        trig_reg <= adc_ctrl_pkg::trig_t'(sfr_req.wdata[`CFG_TRIG_MSB:`CFG_TRIG_LSB]);
      end
      if (aio_write) begin
        aio_reg <= sfr_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Runs on its own regardless of CPU idle, so an idle-time start
  // still finishes and raises the flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= adc_ctrl_pkg::ST_IDLE;
      step_reg  <= 5'h00;
    end else if (ce) begin
      case (state_reg)
        adc_ctrl_pkg::ST_IDLE: begin
          step_reg <= 5'h00;
          if (start) begin
            state_reg <= adc_ctrl_pkg::ST_CONV;
          end
        end
        adc_ctrl_pkg::ST_CONV: begin
          if (!power_reg || conv_done) begin
            state_reg <= adc_ctrl_pkg::ST_IDLE;
          end else if (tick) begin
            step_reg <= step_reg + 5'h01;
          end
        end
        default: begin
          state_reg <= adc_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Power-up settle counter restarts whenever the block is off
  always_ff @(posedge mclk) begin
    if (rst) begin
      settle_reg <= 12'h000;
    end else if (ce) begin
      if (!power_reg) begin
        settle_reg <= 12'h000;
      end else if (!settled) begin
        settle_reg <= settle_reg + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      res_hi_reg <= `RES_RESET;
      res_lo_reg <= `RES_RESET;
    end else if (ce) begin
      // Both bytes in one edge: a read never mixes two conversions
      if (conv_done) begin
        res_hi_reg <= fmt_hi;
        res_lo_reg <= fmt_lo;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port 1 digital input gating
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      p1_meta_reg <= 8'h00;
      p1_sync_reg <= 8'h00;
    end else if (ce) begin
      p1_meta_reg <= p1_pin_in;
      p1_sync_reg <= p1_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      sfr_rdata     <= 8'h00;
      conv_irq      <= 1'b0;
      analog_ctrl   <= '0;
      sar_sample    <= 1'b0;
      sar_step      <= 1'b0;
      p1_digital_in <= 8'h00;
      p1_in_buf_off <= 8'h00;
    end else if (ce) begin
      sfr_rdata     <= rd_mux;
      conv_irq      <= done_next && conv_irq_enable;
      sar_sample    <= start;
      sar_step      <= busy && tick && power_reg;
      p1_digital_in <= p1_sync_reg & ~aio_reg;
      p1_in_buf_off <= aio_reg;
      analog_ctrl.conv_power_on <= power_reg;
      analog_ctrl.diff_mode_sel <= diff_reg;
      analog_ctrl.auto_zero_on  <= az_reg;
      analog_ctrl.pos_input     <= diff_reg ? {chs_reg[2:1], 1'b0} : chs_reg;
      analog_ctrl.neg_input     <= {chs_reg[2:1], 1'b1};
      analog_ctrl.neg_is_ground <= !diff_reg;
    end
  end

endmodule

// ==== rtl/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    TRIG_SOFT,
    TRIG_TIMER0,
    TRIG_FREE,
    TRIG_TIMER3
  } trig_t;

  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } conv_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic timer0_overflow;
    logic timer3_overflow;
    logic timer3_low_half_overflow;
    logic timer3_split;
    logic uart1_baud_timer_overflow;
  } timer_events_t;

  typedef struct packed {
    logic       conv_power_on;
    logic       diff_mode_sel;
    logic       auto_zero_on;
    logic [2:0] pos_input;
    logic [2:0] neg_input;
    logic       neg_is_ground;
  } analog_ctrl_t;

endpackage

// ==== rtl/adc_ctrl_regs.svh ====
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// ----------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------
`define AIO_ADDR       8'h92
`define CFG_ADDR       8'hc3
`define CTL_ADDR       8'hc4
`define RES_LO_ADDR    8'hc5
`define RES_HI_ADDR    8'hc6
`define AIO_RESET      8'h00
`define CFG_RESET      8'h00
`define CTL_RESET      8'h00
`define RES_RESET      8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_POWER_BIT  7
`define CTL_DIFF_BIT   6
`define CTL_AZ_BIT     5
`define CTL_DONE_BIT   4
`define CTL_GO_BIT     3
`define CTL_CHS_MSB    2
`define CTL_CHS_LSB    0
`define CFG_CKS_MSB    7
`define CFG_CKS_LSB    5
`define CFG_RJ_BIT     4
`define CFG_TRIG_MSB   1
`define CFG_TRIG_LSB   0

// ----------------------------------------------------------------
// Clock source codes and timing
// ----------------------------------------------------------------
`define CKS_UART1      3'h6
`define CKS_TIMER3     3'h7
`define CLK_PERIOD_NS  4
`define PWRUP_NS       5000
`define PWRUP_CYC      ((`PWRUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CLOCKS    24

`endif

// ==== rtl/conv_clock_gen.sv ====
`timescale 1ns/10ps
`include "adc_ctrl_regs.svh"

module conv_clock_gen (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic [2:0]                 clock_sel,
  input  wire adc_ctrl_pkg::timer_events_t tev,
  output logic                            tick
);

  logic [5:0] div_cnt_reg;
  logic       half_reg;
  logic [5:0] div_mask;
  logic       sys_tick;
  logic       src_ovf;
  logic       timer_sel;

  // Mask of the low (sel+1) bits: all ones there marks one period
  assign div_mask  = 6'((7'h2 << clock_sel) - 7'h1);
  assign sys_tick  = &(div_cnt_reg | ~div_mask);
  assign timer_sel = (clock_sel == `CKS_UART1) || (clock_sel == `CKS_TIMER3);
  assign src_ovf   = (clock_sel == `CKS_UART1) ? tev.uart1_baud_timer_overflow :
                     tev.timer3_split ? tev.timer3_low_half_overflow :
                     tev.timer3_overflow;

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_cnt_reg <= 6'h00;
      half_reg    <= 1'b0;
      tick        <= 1'b0;
    end else if (ce) begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
      if (src_ovf) begin
        half_reg <= ~half_reg;
      end
      // Overflow sources are halved, every second overflow ticks
      tick <= timer_sel ? (src_ovf & half_reg) : sys_tick;
    end
  end

endmodule

// ==== rtl/result_format.sv ====
`timescale 1ns/10ps

module result_format (
  input  wire logic [11:0] code,
  input  wire logic        diff_mode_sel,
  input  wire logic        right_justify,
  output logic [7:0]       high_byte,
  output logic [7:0]       low_byte
);

  logic [11:0] value;

  // Core delivers offset binary in differential mode; flipping the
  // sign bit turns it into two's complement
  assign value     = diff_mode_sel ? {~code[11], code[10:0]} : code;
  assign high_byte = right_justify ? {4'h0, value[11:8]} : value[11:4];
  assign low_byte  = right_justify ? value[7:0] : {value[3:0], 4'h0};

endmodule
